// ==== design/asra_pkg.sv ====
// Constants shared by the serial register access block
package asra_pkg;
   localparam int          FRAME_BITS   = 16;
   localparam int          DATA_BITS    = 14;
   localparam int          CAL_COUNT    = 10;
   localparam int          BUS_AW       = 8;
   localparam int          BUS_DW       = 32;
   // Write address field, top of frame
   localparam int          WSEL_HI_POS  = 15;
   localparam int          WSEL_LO_POS  = 14;
   localparam logic [1:0]  WSEL_NONE    = 2'h0;
   localparam logic [1:0]  WSEL_TEST    = 2'h1;
   localparam logic [1:0]  WSEL_CAL     = 2'h2;
   localparam logic [1:0]  WSEL_CTRL    = 2'h3;
   // Control register fields
   localparam int          READ_SEL_HI  = 7;
   localparam int          READ_SEL_LO  = 6;
   localparam int          CAL_PICK_HI  = 2;
   localparam int          CAL_PICK_LO  = 1;
   localparam int          CAL_START    = 0;
   localparam logic [13:0] CTRL_RESET   = 14'h0000;
   localparam logic [1:0]  RSEL_DATA    = 2'h0;
   localparam logic [1:0]  RSEL_TEST    = 2'h1;
   localparam logic [1:0]  RSEL_CAL     = 2'h2;
   localparam logic [1:0]  RSEL_STATUS  = 2'h3;
   localparam logic [1:0]  LEAD_ZEROS   = 2'h0;
   // Local register bus map, byte addresses
   localparam logic [7:0]  OFS_RESULT   = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_CTRL     = 8'h08;
   localparam logic [7:0]  OFS_TEST     = 8'h0C;
   localparam logic [7:0]  OFS_FRAMES   = 8'h10;
   localparam logic [7:0]  OFS_CAL_BASE = 8'h40;
   localparam logic [13:0] TEST_RESET   = 14'h0000;
   localparam logic [13:0] CAL_RESET    = 14'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [4:0]  LAST_BIT     = 5'h0F;

   typedef enum logic [1:0] {ASRA_IDLE, ASRA_SHIFT, ASRA_DONE} asra_state_t;
endpackage

// ==== design/asra_top.sv ====
// Serial register access: frame shifter, write decode, read select, local bus
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviour
// - write frame is 16 bits, two select bits then 14 payload bits
// - registers update only after all sixteen bits arrived
// - select code 00 writes nothing and drops the payload
// - select code 01 writes payload into test register
// - select code 10 writes payload into selected calibration register
// - select code 11 writes payload into control register
// - control bits 7 and 6 choose the read frame source
// - read select is 00 after reset, giving output data
// - read select persists until a new control write changes it
// - select 00 returns output data with two leading zeros
// - select 01 returns test register on every read frame
// - select 10 returns currently selected calibration register
// - select 11 returns status register
// - control write-only, data and status read-only, test and cal both
// - every control register bit is zero after reset
// - with start bit 0 the two pick bits choose calibration register
module asra_top
   import asra_pkg::*;
#(
   parameter int CAL_NUM = CAL_COUNT
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 sclk,
   input  wire logic                 sync_n,
   input  wire logic                 din,
   output logic                      dout,
   output logic [DATA_BITS-1:0]      ctrl_word,
   output logic                      frame_written,
   input  wire logic [BUS_AW-1:0]    bus_addr,
   input  wire logic [BUS_DW-1:0]    bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic [BUS_DW-1:0]         bus_rdata
);

   logic [2:0]              sclk_sync_reg;
   logic [2:0]              sync_n_sync_reg;
   logic [1:0]              din_sync_reg;
   logic                    sclk_fall;
   logic                    sclk_rise;
   logic                    frame_start;
   logic                    frame_end;
   asra_state_t             state_reg;
   logic [4:0]              bit_cnt_reg;
   logic [FRAME_BITS-2:0]   in_word_reg;
   logic [FRAME_BITS-1:0]   out_word_reg;
   logic                    dout_reg;
   logic [FRAME_BITS-1:0]   frame_word;
   logic                    commit;
   logic [1:0]              wsel;
   logic [DATA_BITS-1:0]    payload;
   logic [DATA_BITS-1:0]    ctrl_reg;
   logic [DATA_BITS-1:0]    test_reg;
   logic [DATA_BITS-1:0]    cal_reg [CAL_NUM];
   logic [DATA_BITS-1:0]    result_reg;
   logic [FRAME_BITS-1:0]   status_reg;
   logic [15:0]             frames_reg;
   logic [BUS_DW-1:0]       bus_rdata_reg;
   logic                    written_reg;
   logic [1:0]              read_sel;
   logic [1:0]              cal_pick;
   logic                    cal_open;
   logic [FRAME_BITS-1:0]   read_word;

   // Bus byte address to calibration index, or CAL_NUM when not a slot
   function automatic int cal_index(input logic [BUS_AW-1:0] a);
      int idx;
      idx = CAL_NUM;
      for (int i = 0; i < CAL_NUM; i++) begin
         if (a == OFS_CAL_BASE + BUS_AW'(4 * i)) begin
            idx = i;
         end
      end
      return idx;
   endfunction

   // Pins come from the host's clock world: two stages before use
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_sync_reg   <= 3'h7;
         sync_n_sync_reg <= 3'h7;
         din_sync_reg    <= 2'h0;
      end else begin
         sclk_sync_reg   <= {sclk_sync_reg[1:0], sclk};
         sync_n_sync_reg <= {sync_n_sync_reg[1:0], sync_n};
         din_sync_reg    <= {din_sync_reg[0], din};
      end
   end

   // Edge detection looks only at stages two and three
   assign sclk_fall   = sclk_sync_reg[2] & ~sclk_sync_reg[1];
   assign sclk_rise   = ~sclk_sync_reg[2] & sclk_sync_reg[1];
   assign frame_start = sync_n_sync_reg[2] & ~sync_n_sync_reg[1];
   assign frame_end   = sync_n_sync_reg[1];

   assign read_sel = {ctrl_reg[READ_SEL_HI], ctrl_reg[READ_SEL_LO]};
   assign cal_pick = {ctrl_reg[CAL_PICK_HI], ctrl_reg[CAL_PICK_LO]};
   assign cal_open = ~ctrl_reg[CAL_START];

   // Sixteenth falling edge completes the frame
   assign frame_word = {in_word_reg, din_sync_reg[1]};
   assign commit     = (state_reg == ASRA_SHIFT) && !frame_end && sclk_fall
                       && (bit_cnt_reg == LAST_BIT);
   assign wsel       = {frame_word[WSEL_HI_POS], frame_word[WSEL_LO_POS]};
   assign payload    = frame_word[DATA_BITS-1:0];

   always_comb begin
      case (read_sel)
         RSEL_DATA:   read_word = {LEAD_ZEROS, result_reg};
         RSEL_TEST:   read_word = {LEAD_ZEROS, test_reg};
         RSEL_CAL:    read_word = {LEAD_ZEROS, cal_reg[cal_pick]};
         RSEL_STATUS: read_word = status_reg;
         default:     read_word = '0;
      endcase
   end

   // Frame sequencing; a frame cut short by sync going high is dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg   <= ASRA_IDLE;
         bit_cnt_reg <= 5'h00;
         in_word_reg <= '0;
      end else begin
         case (state_reg)
            ASRA_IDLE: begin
               bit_cnt_reg <= 5'h00;
               if (frame_start) begin
                  state_reg <= ASRA_SHIFT;
               end
            end
            ASRA_SHIFT: begin
               if (frame_end) begin
                  state_reg <= ASRA_IDLE;
               end else if (sclk_fall) begin
                  in_word_reg <= frame_word[FRAME_BITS-2:0];
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (commit) begin
                     state_reg <= ASRA_DONE;
                  end
               end
            end
            ASRA_DONE: begin
               // Extra clocks after a full word are ignored
               if (frame_end) begin
                  state_reg <= ASRA_IDLE;
               end
            end
            default: state_reg <= ASRA_IDLE;
         endcase
      end
   end

   // Read word: chosen at frame start, shifted on rising clock edges
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_word_reg <= '0;
         dout_reg     <= 1'b0;
      end else if (state_reg == ASRA_IDLE && frame_start) begin
         out_word_reg <= read_word;
         dout_reg     <= read_word[FRAME_BITS-1];
      end else if (state_reg == ASRA_SHIFT && !frame_end && sclk_rise
                   && bit_cnt_reg != 5'h00) begin
         out_word_reg <= {out_word_reg[FRAME_BITS-2:0], 1'b0};
         dout_reg     <= out_word_reg[FRAME_BITS-2];
      end else if (state_reg == ASRA_IDLE) begin
         dout_reg <= 1'b0;
      end
   end

   // Control register: host write only, cleared at reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (commit && wsel == WSEL_CTRL) begin
         ctrl_reg <= payload;
      end
   end

   // Test register: bus can only read it back
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         test_reg <= TEST_RESET;
      end else if (commit && wsel == WSEL_TEST) begin
         test_reg <= payload;
      end
   end

   // Calibration slots; the serial write wins a same-cycle clash
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < CAL_NUM; i++) begin
            cal_reg[i] <= CAL_RESET;
         end
      end else if (commit && wsel == WSEL_CAL) begin
         if (cal_open) begin
            cal_reg[cal_pick] <= payload;
         end
      end else if (bus_wr && cal_index(bus_addr) < CAL_NUM) begin
         cal_reg[cal_index(bus_addr)] <= bus_wdata[DATA_BITS-1:0];
      end
   end

   // Converter side fills the read-only output data and status words
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_reg <= '0;
         status_reg <= STATUS_RESET;
      end else if (bus_wr) begin
         if (bus_addr == OFS_RESULT) begin
            result_reg <= bus_wdata[DATA_BITS-1:0];
         end
         if (bus_addr == OFS_STATUS) begin
            status_reg <= bus_wdata[FRAME_BITS-1:0];
         end
      end
   end

   // Completed frame counter and write pulse; null frames count but give no pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frames_reg  <= 16'h0000;
         written_reg <= 1'b0;
      end else begin
         written_reg <= commit && wsel != WSEL_NONE;
         if (commit) begin
            frames_reg <= frames_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_rdata_reg <= '0;
      end else if (bus_rd) begin
         if (bus_addr == OFS_RESULT) begin
            bus_rdata_reg <= BUS_DW'(result_reg);
         end else if (bus_addr == OFS_STATUS) begin
            bus_rdata_reg <= BUS_DW'(status_reg);
         end else if (bus_addr == OFS_CTRL) begin
            bus_rdata_reg <= BUS_DW'(ctrl_reg);
         end else if (bus_addr == OFS_TEST) begin
            bus_rdata_reg <= BUS_DW'(test_reg);
         end else if (bus_addr == OFS_FRAMES) begin
            bus_rdata_reg <= BUS_DW'(frames_reg);
         end else if (cal_index(bus_addr) < CAL_NUM) begin
            bus_rdata_reg <= BUS_DW'(cal_reg[cal_index(bus_addr)]);
         end else begin
            bus_rdata_reg <= '0;
         end
      end else begin
         bus_rdata_reg <= '0;
      end
   end

   assign dout          = dout_reg;
   assign ctrl_word     = ctrl_reg;
   assign frame_written = written_reg;
   assign bus_rdata     = bus_rdata_reg;

   property p_ctrl_reset;
      @(posedge clk) sys_rst |=> ctrl_reg == CTRL_RESET && read_sel == RSEL_DATA;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared");

   property p_partial_drop;
      @(posedge clk) disable iff (sys_rst)
         (state_reg == ASRA_SHIFT && frame_end && bit_cnt_reg != 5'h00)
         |=> $stable(ctrl_reg) && $stable(test_reg) && state_reg == ASRA_IDLE;
   endproperty
   a_partial_drop: assert property (p_partial_drop) else $error("partial frame wrote");

   property p_null_write;
      @(posedge clk) disable iff (sys_rst)
         commit && wsel == WSEL_NONE |=> $stable(ctrl_reg) && $stable(test_reg) && !frame_written;
   endproperty
   a_null_write: assert property (p_null_write) else $error("null frame wrote");

   property p_test_write;
      @(posedge clk) disable iff (sys_rst)
         commit && wsel == WSEL_TEST |=> test_reg == $past(payload) && $stable(ctrl_reg);
   endproperty
   a_test_write: assert property (p_test_write) else $error("test write lost");

   property p_cal_write;
      @(posedge clk) disable iff (sys_rst)
         commit && wsel == WSEL_CAL && cal_open |=> cal_reg[$past(cal_pick)] == $past(payload);
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("cal write lost");

   property p_ctrl_write;
      @(posedge clk) disable iff (sys_rst)
         commit && wsel == WSEL_CTRL |=> ctrl_word == $past(payload) && frame_written;
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_sel_persist;
      @(posedge clk) disable iff (sys_rst) !(commit && wsel == WSEL_CTRL) |=> $stable(read_sel);
   endproperty
   a_sel_persist: assert property (p_sel_persist) else $error("read select moved");

   property p_read_data;
      @(posedge clk) disable iff (sys_rst)
         state_reg == ASRA_IDLE && frame_start && read_sel == RSEL_DATA
         |=> out_word_reg[FRAME_BITS-1 -: 2] == LEAD_ZEROS && dout == 1'b0;
   endproperty
   a_read_data: assert property (p_read_data) else $error("data word lacks zeros");

   property p_read_status;
      @(posedge clk) disable iff (sys_rst)
         state_reg == ASRA_IDLE && frame_start && read_sel == RSEL_STATUS
         |=> out_word_reg == $past(status_reg) && dout == $past(status_reg[FRAME_BITS-1]);
   endproperty
   a_read_status: assert property (p_read_status) else $error("status not loaded");

   property p_read_test;
      @(posedge clk) disable iff (sys_rst)
         state_reg == ASRA_IDLE && frame_start && read_sel == RSEL_TEST
         |=> out_word_reg[DATA_BITS-1:0] == $past(test_reg);
   endproperty
   a_read_test: assert property (p_read_test) else $error("test not loaded");

endmodule

// ==== verif/asra_host.sv ====
// Host-side serial master model that frames and shifts words for the block
`timescale 1ns/1ps
module asra_host #(
   parameter real HALF_NS = 62.5
) (
   output logic      sclk,
   output logic      sync_n,
   output logic      din,
   input  wire logic dout
);
   initial begin
      sclk   = 1'b1;
      sync_n = 1'b1;
      din    = 1'b1;
   end

   // Cutting nbits short raises frame sync early, which must drop the frame
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
      r      = 16'h0000;
      sync_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         din = w[i];
         #(HALF_NS);
         r[i] = dout;
         sclk = 1'b0;
         #(HALF_NS);
         sclk = 1'b1;
      end
      #(HALF_NS);
      sync_n = 1'b1;
      // Released line must not keep showing the last bit
      din = ~din;
      #(100);
   endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the serial register access block
`timescale 1ns/1ps
module tb;
   import asra_pkg::*;
   logic                 clk;
   logic                 sys_rst;
   wire logic            sclk;
   wire logic            sync_n;
   wire logic            din;
   logic                 dout;
   logic [DATA_BITS-1:0] ctrl_word;
   logic                 frame_written;
   logic [BUS_AW-1:0]    bus_addr;
   logic [BUS_DW-1:0]    bus_wdata;
   logic                 bus_wr;
   logic                 bus_rd;
   logic [BUS_DW-1:0]    bus_rdata;
   int                   errors;
   int                   n_compared;
   int                   fw_cnt;
   logic [15:0]          rd;
   logic [31:0]          bv;

   asra_top #(.CAL_NUM(CAL_COUNT)) i_dut (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .sclk          (sclk),
      .sync_n        (sync_n),
      .din           (din),
      .dout          (dout),
      .ctrl_word     (ctrl_word),
      .frame_written (frame_written),
      .bus_addr      (bus_addr),
      .bus_wdata     (bus_wdata),
      .bus_wr        (bus_wr),
      .bus_rd        (bus_rd),
      .bus_rdata     (bus_rdata)
   );

   asra_host i_host (
      .sclk   (sclk),
      .sync_n (sync_n),
      .din    (din),
      .dout   (dout)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (frame_written === 1'b1) begin
         fw_cnt++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1;
      chk(bus_rdata, exp);
   endtask

   // Whole or cut frame; dfw is how many write pulses it should cause
   task automatic frm(input logic [15:0] w, input int n, input int dfw);
      int c0;
      c0 = fw_cnt;
      i_host.xfer(w, n, rd);
      chk(32'(fw_cnt - c0), 32'(dfw));
   endtask

   task automatic t_reset;
      chk({18'h0, ctrl_word}, 32'h0);
      bus_read(OFS_CTRL, 32'h0);
      bus_read(OFS_TEST, 32'h0);
   endtask

   task automatic t_data_select;
      bus_write(OFS_RESULT, 32'h0000_3ABC);
      frm(16'h2155, FRAME_BITS, 0);
      chk({16'h0, rd}, 32'h0000_3ABC);
      chk({18'h0, ctrl_word}, 32'h0);
      bus_read(OFS_TEST, 32'h0);
   endtask

   task automatic t_partial;
      frm({WSEL_CTRL, 14'h3FFF}, FRAME_BITS - 1, 0);
      chk({18'h0, ctrl_word}, 32'h0);
   endtask

   task automatic t_test_reg;
      // Normally left alone by the host; written here only to prove the path
      frm({WSEL_TEST, 14'h2A5C}, FRAME_BITS, 1);
      bus_read(OFS_TEST, 32'h0000_2A5C);
      frm({WSEL_CTRL, 14'h2040}, FRAME_BITS, 1);
      chk({18'h0, ctrl_word}, 32'h0000_2040);
      bus_read(OFS_CTRL, 32'h0000_2040);
      frm(16'h0000, FRAME_BITS, 0);
      chk({16'h0, rd}, 32'h0000_2A5C);
      frm(16'h0000, FRAME_BITS, 0);
      chk({16'h0, rd}, 32'h0000_2A5C);
   endtask

   task automatic t_cal;
      frm({WSEL_CTRL, 14'h0084}, FRAME_BITS, 1);
      frm({WSEL_CAL, 14'h1357}, FRAME_BITS, 1);
      bus_read(OFS_CAL_BASE + 8'h08, 32'h0000_1357);
      bus_read(OFS_CAL_BASE + 8'h04, 32'h0);
      frm(16'h0000, FRAME_BITS, 0);
      chk({16'h0, rd}, 32'h0000_1357);
      // Start bit set: pick bits no longer address a coefficient
      frm({WSEL_CTRL, 14'h0085}, FRAME_BITS, 1);
      frm({WSEL_CAL, 14'h0FFF}, FRAME_BITS, 1);
      bus_read(OFS_CAL_BASE + 8'h08, 32'h0000_1357);
   endtask

   task automatic t_status;
      bus_write(OFS_STATUS, 32'h0000_C3A5);
      frm({WSEL_CTRL, 14'h00C0}, FRAME_BITS, 1);
      frm(16'h0000, FRAME_BITS, 0);
      chk({16'h0, rd}, 32'h0000_C3A5);
      bus_write(OFS_CTRL, 32'h0000_3FFF);
      bus_read(OFS_CTRL, 32'h0000_00C0);
      bus_read(8'hFC, 32'h0);
      // Twelve whole frames so far; the cut one is not counted
      bus_read(OFS_FRAMES, 32'h0000_000C);
   endtask

   task automatic wrap_up;
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #500000;
      errors++;
      wrap_up();
   end

   initial begin
      errors     = 0;
      n_compared = 0;
      fw_cnt     = 0;
      sys_rst    = 1'b1;
      bus_addr   = 8'h00;
      bus_wdata  = 32'h0;
      bus_wr     = 1'b0;
      bus_rd     = 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_reset();
      t_data_select();
      t_partial();
      t_test_reg();
      t_cal();
      t_status();
      wrap_up();
   end
endmodule
